// *** rtl/pgm_map_pkg.sv ***
// Package: widths, layout constants and carrier types for the program space mapper
package pgm_map_pkg;
  localparam int DATA_W = 16;
  localparam int PROG_W = 24;
  localparam int PAGE_W = 8;
  localparam int WIN_BIT = 15;
  localparam int LOW_W = 15;
  localparam int CFG_BIT = 23;
  localparam int BYTE_W = 8;
  localparam logic [7:0] PAGE_RST = 8'h00;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_DATA,
    OP_TABLE,
    OP_REMAP
  } path_t;

  // Request from the core load/store unit
  typedef struct packed {
    logic valid;
    logic write;
    logic table_op;
    logic byte_op;
    logic hi_byte;
    logic [DATA_W-1:0] effective_address;
    logic [DATA_W-1:0] wdata;
  } core_req_t;

  // Request toward program memory
  typedef struct packed {
    logic valid;
    logic write;
    logic config_space;
    logic [PROG_W-1:0] addr;
    logic [2:0] lane_en;
    logic [PROG_W-1:0] wdata;
  } prog_req_t;
endpackage : pgm_map_pkg

// *** rtl/addr_former.sv ***
// Combinational program address builder for table and remap paths
`timescale 1ns/1ps
module addr_former (
  // Inputs
  input wire logic [7:0] table_page_i,
  input wire logic [7:0] remap_page_i,
  input wire logic [15:0] ea_i,
  input wire logic table_op_i,
  // Outputs
  output logic [23:0] prog_addr_o,
  output pgm_map_pkg::path_t path_o
);
  wire in_window = ea_i[pgm_map_pkg::WIN_BIT];
  wire [23:0] table_addr = {table_page_i, ea_i}; // [R2] [R3] [R4]
  // EA bit 15 dropped; page bit 0 lands on address bit 15, top bit zero
  wire [23:0] remap_addr = {1'b0, remap_page_i, ea_i[pgm_map_pkg::LOW_W-1:0]}; // [R7] [R8] [R9] [R6]
  assign prog_addr_o = table_op_i ? table_addr : (in_window ? remap_addr : {8'h00, ea_i});
  assign path_o = table_op_i ? pgm_map_pkg::OP_TABLE :
                  (in_window ? pgm_map_pkg::OP_REMAP : pgm_map_pkg::OP_DATA); // [R11]
endmodule : addr_former

// *** rtl/program_space_address_mapper.sv ***
// Top: maps core data-side accesses onto 24-bit program memory
// Contract
// [R1] Bridge 16-bit data space to 24-bit program space keeping word alignment.
// [R2] Table address is table page register above the 16-bit effective address.
// [R3] Each table page value selects a 32K-word program region.
// [R4] Table page top bit picks user (0) or configuration (1) memory.
// [R5] Table ops read and write bytes or words, including the upper byte.
// [R6] Each remap page value selects a 16K-word program page.
// [R7] EA bit 15 set: address is remap page joined to low 15 EA bits.
// [R8] EA bit 15 is dropped; address bit 15 comes from remap page bit 0.
// [R9] Remap accesses force the top address bit to zero, user memory only.
// [R10] Remap is read-only and returns only the low 16-bit word.
// [R11] EA bit 15 clear: plain data access, no remap translation.
`timescale 1ns/1ps
module program_space_address_mapper (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // Page register loads from the core
  input wire logic TBL_PAGE_WE_I,
  input wire logic [7:0] TBL_PAGE_D_I,
  input wire logic REMAP_PAGE_WE_I,
  input wire logic [7:0] REMAP_PAGE_D_I,
  // Core request
  input wire pgm_map_pkg::core_req_t REQ_I,
  // Program memory read data
  input wire logic PM_RVALID_I,
  input wire logic [23:0] PM_RDATA_I,
  // Program memory request
  output pgm_map_pkg::prog_req_t PM_REQ_O,
  // Data-space pass-through
  output logic DATA_VALID_O,
  output logic DATA_WRITE_O,
  output logic [15:0] DATA_ADDR_O,
  output logic [15:0] DATA_WDATA_O,
  // Answer to the core
  output logic RVALID_O,
  output logic [15:0] RDATA_O,
  output logic WR_REJECT_O,
  output logic [7:0] TBL_PAGE_O,
  output logic [7:0] REMAP_PAGE_O
);
  // Byte lane enables of one 24-bit word for a table access
  function automatic logic [2:0] lanes(input logic byte_op, input logic hi, input logic a0);
    if (!byte_op) begin
      lanes = hi ? 3'h4 : 3'h3;
    end else if (hi) begin
      lanes = 3'h4;
    end else begin
      lanes = a0 ? 3'h2 : 3'h1;
    end
  endfunction : lanes

  logic [7:0] table_page_r;
  logic [7:0] remap_page_r;
  pgm_map_pkg::prog_req_t pm_req_r;
  pgm_map_pkg::prog_req_t pm_req_nxt;
  logic data_valid_r;
  logic data_write_r;
  logic [15:0] data_addr_r;
  logic [15:0] data_wdata_r;
  logic rvalid_r;
  logic rej_r;
  logic [15:0] rdata_r;
  pgm_map_pkg::path_t pend_r;
  pgm_map_pkg::path_t pend_nxt;
  logic pend_byte_r;
  logic pend_hi_r;
  logic pend_a0_r;

  logic [23:0] prog_addr;
  pgm_map_pkg::path_t path;

  addr_former u_former (
    .table_page_i(table_page_r),
    .remap_page_i(remap_page_r),
    .ea_i(REQ_I.effective_address),
    .table_op_i(REQ_I.table_op),
    .prog_addr_o(prog_addr),
    .path_o(path)
  );

  // Path decode of the request taken at this edge
  wire go = REQ_I.valid;
  wire is_table = go && (path == pgm_map_pkg::OP_TABLE);
  wire is_remap = go && (path == pgm_map_pkg::OP_REMAP);
  wire is_data = go && (path == pgm_map_pkg::OP_DATA);
  // Writes through the remap window are dropped, never forwarded
  wire remap_wr = is_remap && REQ_I.write; // [R10]
  wire tbl_cfg = table_page_r[pgm_map_pkg::PAGE_W-1]; // [R4]
  wire [2:0] req_lanes = lanes(REQ_I.byte_op, REQ_I.hi_byte, REQ_I.effective_address[0]);
  // Write data is steered into the lane it targets; upper byte reaches bits 23:16
  wire [23:0] tbl_wdata = REQ_I.hi_byte ? {REQ_I.wdata[7:0], 16'h0000} :
                          (REQ_I.byte_op ? {8'h00, REQ_I.wdata[7:0], REQ_I.wdata[7:0]} :
                           {8'h00, REQ_I.wdata}); // [R5]
  // Byte lanes of the returned word, lane 0 lowest
  wire [7:0] rd_lane [0:2];
  for (genvar g = 0; g < 3; g++) begin : g_rd_lane
    assign rd_lane[g] = PM_RDATA_I[g*pgm_map_pkg::BYTE_W +: pgm_map_pkg::BYTE_W];
  end
  // Read answer: remap yields low word only; table may pick any byte
  wire [7:0] sel_byte = pend_hi_r ? rd_lane[2] :
                        (pend_a0_r ? rd_lane[1] : rd_lane[0]);
  wire [15:0] tbl_rdata = pend_hi_r ? {8'h00, rd_lane[2]} :
                          (pend_byte_r ? {8'h00, sel_byte} : PM_RDATA_I[15:0]); // [R5]
  wire [15:0] rd_word = (pend_r == pgm_map_pkg::OP_REMAP) ? PM_RDATA_I[15:0] : tbl_rdata; // [R10]
  wire rd_done = PM_RVALID_I && (pend_r != pgm_map_pkg::OP_NONE);
  // Only reads toward program memory open a pending slot
  wire rd_issue = pm_req_nxt.valid && !pm_req_nxt.write;

  always_comb begin
    pm_req_nxt = '0;
    if (is_table) begin
      pm_req_nxt.valid = 1'b1;
      pm_req_nxt.write = REQ_I.write;
      pm_req_nxt.config_space = tbl_cfg; // [R4]
      pm_req_nxt.addr = prog_addr; // [R1]
      pm_req_nxt.lane_en = req_lanes;
      pm_req_nxt.wdata = tbl_wdata;
    end else if (is_remap && !REQ_I.write) begin
      pm_req_nxt.valid = 1'b1;
      pm_req_nxt.addr = prog_addr; // [R9]
      pm_req_nxt.lane_en = 3'h3;
    end
  end

  // A request in the same cycle as a page load still sees the old page
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      table_page_r <= pgm_map_pkg::PAGE_RST;
      remap_page_r <= pgm_map_pkg::PAGE_RST;
    end else begin
      if (TBL_PAGE_WE_I) table_page_r <= TBL_PAGE_D_I;
      if (REMAP_PAGE_WE_I) remap_page_r <= REMAP_PAGE_D_I;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pm_req_r <= '0;
    end else begin
      pm_req_r <= pm_req_nxt;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      data_valid_r <= 1'b0;
      data_write_r <= 1'b0;
      data_addr_r <= 16'h0000;
      data_wdata_r <= 16'h0000;
    end else begin
      data_valid_r <= is_data; // [R11]
      data_write_r <= is_data && REQ_I.write;
      data_addr_r <= is_data ? REQ_I.effective_address : data_addr_r;
      data_wdata_r <= is_data ? REQ_I.wdata : data_wdata_r;
    end
  end

  // One read outstanding; a new read replaces the pending kind, a return clears it
  always_comb begin
    case (pend_r)
      pgm_map_pkg::OP_TABLE, pgm_map_pkg::OP_REMAP: begin
        pend_nxt = rd_done ? pgm_map_pkg::OP_NONE : pend_r;
      end
      default: begin
        pend_nxt = pgm_map_pkg::OP_NONE;
      end
    endcase
    if (rd_issue) begin
      pend_nxt = path;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pend_r <= pgm_map_pkg::OP_NONE;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pend_byte_r <= 1'b0;
      pend_hi_r <= 1'b0;
      pend_a0_r <= 1'b0;
    end else if (rd_issue) begin
      pend_byte_r <= REQ_I.byte_op;
      pend_hi_r <= REQ_I.hi_byte;
      pend_a0_r <= REQ_I.effective_address[0];
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rvalid_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      rvalid_r <= rd_done;
      rdata_r <= rd_done ? rd_word : rdata_r;
    end
  end

  // A refused remap write still answers, so the core never waits on it
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rej_r <= 1'b0;
    end else begin
      rej_r <= remap_wr; // [R10]
    end
  end

  assign PM_REQ_O = pm_req_r;
  assign DATA_VALID_O = data_valid_r;
  assign DATA_WRITE_O = data_write_r;
  assign DATA_ADDR_O = data_addr_r;
  assign DATA_WDATA_O = data_wdata_r;
  assign RVALID_O = rvalid_r;
  assign RDATA_O = rdata_r;
  assign WR_REJECT_O = rej_r;
  assign TBL_PAGE_O = table_page_r;
  assign REMAP_PAGE_O = remap_page_r;
endmodule : program_space_address_mapper

// *** dv/pgm_map_properties.sv ***
// Checker: port-level properties of the program space mapper
`timescale 1ns/1ps
module pgm_map_chk (
  // Inputs to the mapper
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic TBL_PAGE_WE_I,
  input wire logic [7:0] TBL_PAGE_D_I,
  input wire pgm_map_pkg::core_req_t REQ_I,
  input wire logic PM_RVALID_I,
  // Outputs of the mapper
  input wire pgm_map_pkg::prog_req_t PM_REQ_O,
  input wire logic DATA_VALID_O,
  input wire logic [15:0] DATA_ADDR_O,
  input wire logic RVALID_O,
  input wire logic WR_REJECT_O,
  input wire logic [7:0] TBL_PAGE_O,
  input wire logic [7:0] REMAP_PAGE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  wire e15 = REQ_I.effective_address[15];
  wire tbl = REQ_I.valid && REQ_I.table_op;
  wire rmp = REQ_I.valid && !REQ_I.table_op && e15;
  tbl_addr_a: assert property (tbl |=> PM_REQ_O.valid &&
    PM_REQ_O.addr == {$past(TBL_PAGE_O), $past(REQ_I.effective_address)}) else $error("tbl addr");
  cfg_sel_a: assert property (tbl |=> PM_REQ_O.config_space == $past(TBL_PAGE_O[7]))
    else $error("cfg sel");
  hi_lane_a: assert property (tbl && REQ_I.hi_byte |=> PM_REQ_O.lane_en == 3'h4)
    else $error("hi lane");
  remap_addr_a: assert property (rmp && !REQ_I.write |=> PM_REQ_O.valid &&
    PM_REQ_O.addr == {1'b0, $past(REMAP_PAGE_O), $past(REQ_I.effective_address[14:0])})
    else $error("remap addr");
  remap_user_a: assert property (rmp |=> !PM_REQ_O.config_space && !PM_REQ_O.addr[23])
    else $error("remap user");
  remap_wr_a: assert property (rmp && REQ_I.write |=> WR_REJECT_O && !PM_REQ_O.valid)
    else $error("remap write");
  data_path_a: assert property (REQ_I.valid && !REQ_I.table_op && !e15 |=> DATA_VALID_O &&
    !PM_REQ_O.valid && DATA_ADDR_O == $past(REQ_I.effective_address)) else $error("data path");
  rd_ret_a: assert property (PM_RVALID_I |=> RVALID_O) else $error("read return");
  page_load_a: assert property (TBL_PAGE_WE_I |=> TBL_PAGE_O == $past(TBL_PAGE_D_I))
    else $error("page load");
endmodule : pgm_map_chk
bind program_space_address_mapper pgm_map_chk u_pgm_map_chk (.CLK_I, .NRST_I, .TBL_PAGE_WE_I,
  .TBL_PAGE_D_I, .REQ_I, .PM_RVALID_I, .PM_REQ_O, .DATA_VALID_O, .DATA_ADDR_O, .RVALID_O,
  .WR_REJECT_O, .TBL_PAGE_O, .REMAP_PAGE_O);

// *** dv/pm_model.sv ***
// Program memory model answering mapper reads one cycle after the request
`timescale 1ns/1ps
module pm_model (
  input wire logic clk_i,
  input wire pgm_map_pkg::prog_req_t req_i,
  output logic rvalid_o,
  output logic [23:0] rdata_o
);
  wire rd = req_i.valid && !req_i.write;
  initial rvalid_o = 1'b0;
  initial rdata_o = 24'h0;
  always @(posedge clk_i) begin
    rvalid_o <= rd;
    // Idle data toggles so a stale sample never matches
    rdata_o <= rd ? {req_i.addr[7:0] ^ 8'h3c, req_i.addr[23:8]} : ~rdata_o;
  end
endmodule : pm_model

// *** dv/program_space_address_mapper_tb.sv ***
// Testbench: corner and random requests through the program space mapper
`timescale 1ns/1ps
module program_space_address_mapper_tb;
  logic clk = 0, nrst = 0, twe = 0, rwe = 0, pmv, dv, dw, rv, rj;
  logic [7:0] td = 0, rd = 0, tp = 0, rp = 0, tpo, rpo;
  logic [23:0] pmd;
  logic [15:0] da, rdat, dwd;
  pgm_map_pkg::core_req_t req = '0;
  pgm_map_pkg::prog_req_t pm;
  int err_total = 0, num_checks = 0, seed = 32'h4c7f, k;
  initial forever #10 clk = ~clk;
  pm_model u_pm_model (.clk_i(clk), .req_i(pm), .rvalid_o(pmv), .rdata_o(pmd));
  program_space_address_mapper u_program_space_address_mapper (.CLK_I(clk), .NRST_I(nrst),
    .TBL_PAGE_WE_I(twe), .TBL_PAGE_D_I(td), .REMAP_PAGE_WE_I(rwe), .REMAP_PAGE_D_I(rd),
    .REQ_I(req), .PM_RVALID_I(pmv), .PM_RDATA_I(pmd), .PM_REQ_O(pm), .DATA_VALID_O(dv),
    .DATA_WRITE_O(dw), .DATA_ADDR_O(da), .DATA_WDATA_O(dwd), .RVALID_O(rv), .RDATA_O(rdat),
    .WR_REJECT_O(rj), .TBL_PAGE_O(tpo), .REMAP_PAGE_O(rpo));
  task chk(input string n, input logic [23:0] e, g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task pages(input logic [7:0] t, r);
    @(posedge clk);
    #1 {twe, rwe, td, rd} = {2'b11, t, r};
    @(posedge clk);
    #1 {twe, rwe, tp, rp} = {2'b00, t, r};
    chk("pages", {8'h0, t, r}, {8'h0, tpo, rpo});
  endtask : pages
  // Expected program address from the page values the bench last loaded
  function automatic logic [23:0] exp_addr(input logic t, input logic [15:0] ea);
    exp_addr = t ? {tp, ea} : {1'b0, rp, ea[14:0]};
  endfunction : exp_addr
  task op(input logic t, w, b, h, input logic [15:0] ea, wd);
    logic [23:0] a, p, x;
    logic [2:0] ln;
    a = exp_addr(t, ea);
    p = {a[7:0] ^ 8'h3c, a[23:8]};
    ln = h ? 3'h4 : b ? {1'b0, ea[0], !ea[0]} : 3'h3;
    x = h ? {16'h0, p[23:16]} : b ? {16'h0, ea[0] ? p[15:8] : p[7:0]} : {8'h0, p[15:0]};
    @(posedge clk);
    #1 req = '{1'b1, w, t, b, h, ea, wd};
    @(posedge clk);
    #1 req.valid = 1'b0;
    if (!t && !ea[15]) begin
      chk("data", {6'h1, w, ea}, {pm.valid, 5'h0, dv, dw, da});
      if (w) chk("data wdata", {8'h0, wd}, {8'h0, dwd});
    end else if (!t && w) chk("reject", 24'h2, {22'h0, rj, pm.valid});
    else begin
      chk("pm addr", a, pm.addr);
      chk("pm ctl", {18'h1, t & tp[7], w, ln}, {18'h0, pm.valid, pm.config_space,
        pm.write, pm.lane_en});
      if (w && !b) chk("pm wdata", h ? {wd[7:0], 16'h0} : {8'h0, wd}, pm.wdata);
      if (w && b) chk("pm wbyte", {16'h0, wd[7:0]},
        {16'h0, ea[0] ? pm.wdata[15:8] : pm.wdata[7:0]});
      for (k = 0; k < 4 && rv !== 1'b1 && !w; k++) begin
        @(posedge clk);
        #1;
      end
      if (!w && rv !== 1'b1) begin
        err_total++;
        tally_and_finish;
      end
      if (!w) chk("rdata", x, {8'h0, rdat});
    end
  endtask : op
  initial begin
    repeat (6) @(posedge clk);
    #1 nrst = 1;
    chk("reset", 24'h0, {tpo, rpo, 7'h0, pm.valid});
    pages(8'h05, 8'h05);
    op(0, 0, 0, 0, 16'h8123, 0);
    pages(8'h81, 8'hff);
    op(1, 1, 0, 1, 16'hffff, 16'h1234);
    op(1, 0, 0, 1, 16'h0000, 0);
    op(1, 0, 1, 0, 16'h7ffe, 0);
    op(1, 0, 1, 0, 16'h7fff, 0);
    op(0, 0, 0, 0, 16'hffff, 0);
    op(0, 1, 0, 0, 16'h8000, 16'h5555);
    op(0, 1, 0, 0, 16'h7fff, 16'haaaa);
    repeat (200) begin
      k = $random(seed);
      if (k[7:4] == 0) pages($random(seed), $random(seed));
      op(k[0], k[1], k[0] & k[2], k[0] & !k[2] & k[3], $random(seed), $random(seed));
    end
    tally_and_finish;
  end
endmodule : program_space_address_mapper_tb
